// ### core/pos_core.sv
// command interpreter for on/off, fault clear, write protection and store
`timescale 1ns/1ps
`include "pos_consts.svh"
module pos_core (
  input  wire logic              i_mclk,
  input  wire logic              i_nrst,
  input  wire logic              i_link_clk,
  input  wire logic              i_link_nrst,
  input  wire logic              i_req_valid,
  input  wire pos_pkg::pos_req_t i_req,
  output logic                   o_link_busy,
  output logic                   o_rsp_valid,
  output logic [15:0]            o_rsp_data,
  input  wire logic              i_control_pin,
  input  wire logic              i_fault_event,
  input  wire logic              i_fault_present,
  input  wire logic [1:0]        i_fault_shutdown,
  input  wire logic              i_flash_done,
  input  wire logic              i_flash_err,
  output pos_pkg::pos_flash_t    o_flash,
  output logic [1:0]             o_supply_enable_out,
  output logic [1:0]             o_fast_off,
  output logic                   o_monitor_hold,
  output logic                   o_alert
);
  import pos_pkg::*;

  // ----------------------------------------------------------------------
  // link domain: capture one transaction and hand it over by toggle
  // ----------------------------------------------------------------------
  logic        req_tgl;
  pos_req_t    req_hold;
  logic        ack_link;
  logic [15:0] rsp_hold;
  logic        ack_tgl;

  // request words stay frozen from the toggle until the ack returns,
  // so the core may sample them directly without a word crossing
  always_ff @(posedge i_link_clk) begin
    if (!i_link_nrst) begin
      req_tgl     <= 1'b0;
      req_hold    <= '0;
      o_link_busy <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= 16'h0000;
    end else begin
      o_rsp_valid <= 1'b0;
      if (i_req_valid && !o_link_busy) begin
        req_hold    <= i_req;
        req_tgl     <= ~req_tgl;
        o_link_busy <= 1'b1;
      end else if (o_link_busy && (ack_link == req_tgl)) begin
        o_link_busy <= 1'b0;
        o_rsp_valid <= 1'b1;
        o_rsp_data  <= rsp_hold;
      end
    end
  end

  // the acknowledge toggle comes back through the same three-stage filter
  pos_sync u_ack_sync (
    .i_clk  (i_link_clk),
    .i_nrst (i_link_nrst),
    .i_d    (ack_tgl),
    .o_q    (ack_link)
  );

  // ----------------------------------------------------------------------
  // core domain: request detection and pin input
  // ----------------------------------------------------------------------
  logic req_core;
  logic req_seen;
  logic pin_sync;

  pos_sync u_req_sync (
    .i_clk  (i_mclk),
    .i_nrst (i_nrst),
    .i_d    (req_tgl),
    .o_q    (req_core)
  );

  // the pin is asynchronous; a level shorter than two core cycles is
  // filtered out, which also keeps a noisy pin from chattering the enables
  pos_sync u_pin_sync (
    .i_clk  (i_mclk),
    .i_nrst (i_nrst),
    .i_d    (i_control_pin),
    .o_q    (pin_sync)
  );

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  pos_state_t  state;
  logic [7:0]  page;
  logic [7:0]  op_byte;
  logic [7:0]  onoff_cfg;
  logic [7:0]  wp_level;
  logic [7:0]  vmode;
  logic [15:0] store_last;
  logic [1:0]  cmd_on;
  logic [1:0]  latched_off;
  logic        st_fault;
  logic        st_cml;
  logic        pin_on_q;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire       new_req   = (req_core != req_seen) && (state == POS_IDLE);
  wire       wr        = new_req && req_hold.write;
  wire       rd        = new_req && !req_hold.write;
  wire [7:0] code      = req_hold.code;
  wire [7:0] d8        = req_hold.data[7:0];
  wire       dual      = vmode[`POS_VM_DUAL];
  wire       alert_en  = vmode[`POS_VM_ALERT_EN];

  wire is_page  = (code == `POS_CMD_PAGE);
  wire is_op    = (code == `POS_CMD_OPERATION);
  wire is_cfg   = (code == `POS_CMD_ONOFF_CFG);
  wire is_clr   = (code == `POS_CMD_CLR_FAULT);
  wire is_wp    = (code == `POS_CMD_WR_PROT);
  wire is_sall  = (code == `POS_CMD_STORE_ALL);
  wire is_stat  = (code == `POS_CMD_STATUS);
  wire is_vmode = (code == `POS_CMD_VMODE);
  wire is_sone  = (code == `POS_CMD_STORE_ONE);
  wire known    = is_page | is_op | is_cfg | is_clr | is_wp | is_sall
                | is_stat | is_vmode | is_sone;

  // write gate; reads are never gated
  wire wp_allow = (wp_level == `POS_WP_NONE)
                | ((wp_level == `POS_WP_ONLY_WP) & is_wp)
                | ((wp_level == `POS_WP_OP_PAGE) & (is_wp | is_op | is_page))
                | ((wp_level == `POS_WP_PLUS_CFG)
                   & (is_wp | is_op | is_page | is_cfg));
  // a blocked write just disappears, no status touched
  wire wr_ok    = wr && known && wp_allow;

  // on/off data byte classification
  wire op_std   = (d8 == 8'h00) | (d8 == 8'h40) | (d8 == 8'h80) | (d8 == 8'h94)
                | (d8 == 8'h98) | (d8 == 8'ha4) | (d8 == 8'ha8);
  wire op_spc_p = (d8 == 8'h01) | (d8 == 8'h41) | (d8 == 8'h81);
  wire op_spc_s = (d8 == 8'h02) | (d8 == 8'h42) | (d8 == 8'h82);
  // special bytes count only in dual mode with the all-pages setting
  wire spc_ok   = dual && (page == `POS_PAGE_ALL);
  wire op_valid = op_std | ((op_spc_p | op_spc_s) & spc_ok);
  wire op_wr    = wr_ok && is_op && op_valid;
  // standard bytes steer both groups in dual mode
  wire [1:0] op_sel = op_std ? 2'b11 : {op_spc_s, op_spc_p};
  wire       op_fast = (d8[7:6] == 2'b00);
  // only off bytes record a turn-off style; an on byte that the pin still
  // holds back must not relabel an immediate pin turn-off as soft
  wire       op_off  = op_wr && cmd_need && !d8[7];

  // protection levels outside the table are refused as bad data
  wire wp_good  = (d8 == `POS_WP_ONLY_WP) | (d8 == `POS_WP_OP_PAGE)
                | (d8 == `POS_WP_PLUS_CFG) | (d8 == `POS_WP_NONE);

  // comm fault causes: bad operation byte, bad level, unknown or
  // read-only/write-only misuse, and flash transfer errors
  wire bad_op   = wr_ok && is_op && !op_valid;
  wire bad_cmd  = new_req && !known;
  wire bad_dir  = (rd && (is_clr | is_sall)) | (wr_ok && is_stat)
                | (wr_ok && is_wp && !wp_good);
  wire flash_bad = (state == POS_FLASH) && i_flash_done && i_flash_err;
  wire cml_set  = bad_op | bad_cmd | bad_dir | flash_bad;
  wire clr_cmd  = wr_ok && is_clr;

  // ----------------------------------------------------------------------
  // supply on/off combination
  // ----------------------------------------------------------------------
  // pin request after polarity
  wire pin_on   = onoff_cfg[`POS_CFG_PIN_POL] ? pin_sync : ~pin_sync;
  wire pin_need = onoff_cfg[`POS_CFG_PIN_EN];
  wire cmd_need = onoff_cfg[`POS_CFG_CMD_EN];
  // both enabled: both needed to turn on, either turns off
  wire [1:0] on_req = onoff_cfg[`POS_CFG_AUTO]
                    ? ((cmd_need ? cmd_on : 2'b11) & (pin_need ? {2{pin_on}} : 2'b11))
                    : 2'b11;
  wire [1:0] next_enable = on_req & ~latched_off;
  wire       pin_drop   = pin_need && pin_on_q && !pin_on;

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      page       <= `POS_PAGE_ALL;
      op_byte    <= 8'h00;
      onoff_cfg  <= `POS_CFG_RESET;
      wp_level   <= `POS_WP_RESET;
      vmode      <= `POS_VM_RESET;
      store_last <= 16'h0000;
    end else begin
      if (wr_ok && is_page) begin
        page <= d8;
      end
      if (op_wr) begin
        op_byte <= d8 & `POS_OP_STD_MASK;
      end
      if (wr_ok && is_cfg) begin
        onoff_cfg <= d8 & `POS_CFG_MASK;
      end
      if (wr_ok && is_wp && wp_good) begin
        wp_level <= d8;
      end
      if (wr_ok && is_vmode) begin
        vmode <= d8;
      end
      if ((state == POS_FLASH) && i_flash_done && !o_flash.all && !i_flash_err) begin
        store_last <= o_flash.sel;
      end
    end
  end

  // ----------------------------------------------------------------------
  // on/off state per sequence group
  // ----------------------------------------------------------------------
  // fault clear has no path in here, so latched-off groups stay off
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      cmd_on      <= 2'b00;
      latched_off <= 2'b00;
      pin_on_q    <= 1'b0;
    end else begin
      pin_on_q <= pin_on;
      if (op_wr && cmd_need) begin
        cmd_on   <= (cmd_on & ~op_sel) | (op_sel & {2{d8[7]}});
      end
      // only a real off request releases a fault latch
      latched_off <= (latched_off | i_fault_shutdown) & on_req;
    end
  end

  // turn-off style follows the pin drop or the last off byte, never an on byte
  // enables and turn-off style
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_supply_enable_out <= 2'b00;
      o_fast_off          <= 2'b00;
    end else begin
      o_supply_enable_out <= next_enable;
      if (pin_drop) begin
        o_fast_off <= {2{onoff_cfg[`POS_CFG_PIN_FAST]}};
      end else if (op_off) begin
        o_fast_off <= (o_fast_off & ~op_sel) | (op_sel & {2{op_fast}});
      end
    end
  end

  // ----------------------------------------------------------------------
  // status and alert
  // ----------------------------------------------------------------------
  // status bits are set by hardware and cleared only by the fault-clear write
  // set beats clear in the same cycle; a clear reloads the fault bit from
  // the live condition but only a fresh event drives alert again
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      st_fault <= 1'b0;
      st_cml   <= 1'b0;
      o_alert  <= 1'b0;
    end else begin
      if (clr_cmd) begin
        st_fault <= i_fault_present | i_fault_event;
        st_cml   <= cml_set;
        o_alert  <= alert_en & (i_fault_event | cml_set);
      end else begin
        st_fault <= st_fault | i_fault_event;
        st_cml   <= st_cml | cml_set;
        o_alert  <= o_alert | (alert_en & (i_fault_event | cml_set));
      end
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  // read data never looks at the protection level
  wire [15:0] rd_data = is_page  ? {8'h00, page}
                      : is_op    ? {8'h00, op_byte}
                      : is_cfg   ? {8'h00, onoff_cfg & `POS_CFG_MASK}
                      : is_wp    ? {8'h00, wp_level}
                      : is_vmode ? {8'h00, vmode}
                      : is_stat  ? {14'h0000, st_cml, st_fault}
                      : is_sone  ? store_last
                      : 16'h0000;

  // ----------------------------------------------------------------------
  // command sequencer and flash requests
  // ----------------------------------------------------------------------
  wire start_all = wr_ok && is_sall;
  wire start_one = wr_ok && is_sone;

  // one request is worked at a time; the link side keeps its word frozen
  // until the acknowledge toggle returns, so nothing can overtake it
  // store-all holds the reply back, so the host sees no answer until the
  // flash is done, and monitoring is frozen for the whole transfer
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      state          <= POS_IDLE;
      req_seen       <= 1'b0;
      ack_tgl        <= 1'b0;
      rsp_hold       <= 16'h0000;
      o_flash        <= '0;
      o_monitor_hold <= 1'b0;
    end else begin
      unique case (state)
        POS_IDLE: begin
          if (new_req) begin
            req_seen <= req_core;
            rsp_hold <= rd ? rd_data : 16'h0000;
            if (start_all || start_one) begin
              o_flash.start  <= 1'b1;
              o_flash.all    <= start_all;
              o_flash.sel    <= start_one ? req_hold.data : 16'h0000;
              o_monitor_hold <= start_all;
              state          <= POS_FLASH;
            end else begin
              state <= POS_REPLY;
            end
          end
        end
        POS_FLASH: begin
          if (i_flash_done) begin
            o_flash.start  <= 1'b0;
            o_monitor_hold <= 1'b0;
            state          <= POS_REPLY;
          end
        end
        POS_REPLY: begin
          ack_tgl <= req_seen;
          state   <= POS_IDLE;
        end
        default: begin
          state <= POS_IDLE;
        end
      endcase
    end
  end

endmodule

// ### core/pos_consts.svh
// constants for the on/off, protection and store command block
// Functional notes
// - page 255 dual mode: 01h primary fast off, 41h soft off, 81h on
// - page 255 dual mode: 02h secondary fast off, 42h soft off, 82h on
// - dual mode set: standard on/off bytes drive both sequences together
// - on/off readback in dual mode only gives standard byte values
// - sequence-specific bytes are honoured only while page holds 255
// - config bit 4 low: supplies on at bias, control pin ignored
// - config bit 3 low: on/off part of command ignored; high: required
// - config bit 2 low: control pin ignored; high: pin level required
// - config bit 1 sets control pin polarity, 1 means high is on
// - config bit 0: pin turn-off soft when 0, immediate when 1
// - bits 2 and 3 set: both needed for on, either turns off
// - fault clear empties latched status at once and drops alert
// - fault clear never restarts latched-off supplies or moves enables
// - persisting fault re-sets status without alert; only new ones alert
// - reads of every command are allowed whatever the protection level
// - protection 80h/40h/20h gates which command writes are accepted
// - protection 00h allows all writes and is the reset value
// - writes to protected commands are silently dropped
// - store-all saves configuration; transfer error sets comm fault, alert
// - during store-all no bus answer and supply monitoring is held
// - single store takes page/command word, stores it, reads last pair
// - invalid on/off data byte sets comm fault and raises alert
`ifndef POS_CONSTS_SVH
`define POS_CONSTS_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define POS_CMD_PAGE      8'h00
`define POS_CMD_OPERATION 8'h01
`define POS_CMD_ONOFF_CFG 8'h02
`define POS_CMD_CLR_FAULT 8'h03
`define POS_CMD_WR_PROT   8'h10
`define POS_CMD_STORE_ALL 8'h11
`define POS_CMD_STATUS    8'h79
`define POS_CMD_VMODE     8'hd1
`define POS_CMD_STORE_ONE 8'hfc

// ----------------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------------
`define POS_CFG_AUTO      4
`define POS_CFG_CMD_EN    3
`define POS_CFG_PIN_EN    2
`define POS_CFG_PIN_POL   1
`define POS_CFG_PIN_FAST  0
`define POS_CFG_MASK      8'h1f
`define POS_CFG_RESET     8'h1e
`define POS_VM_DUAL       0
`define POS_VM_ALERT_EN   1
`define POS_VM_RESET      8'h02
`define POS_WP_RESET      8'h00
`define POS_WP_ONLY_WP    8'h80
`define POS_WP_OP_PAGE    8'h40
`define POS_WP_PLUS_CFG   8'h20
`define POS_WP_NONE       8'h00
`define POS_PAGE_ALL      8'hff
`define POS_OP_STD_MASK   8'hfc
`define POS_ST_FAULT      0
`define POS_ST_CML        1

`endif

// ### core/pos_pkg.sv
// types shared by the on/off, protection and store command block
package pos_pkg;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } pos_req_t;

  typedef struct packed {
    logic        start;
    logic        all;
    logic [15:0] sel;
  } pos_flash_t;

  typedef enum logic [1:0] {
    POS_IDLE  = 2'b00,
    POS_FLASH = 2'b01,
    POS_REPLY = 2'b10
  } pos_state_t;

endpackage

// ### core/pos_sync.sv
// three-stage synchroniser, output moves once stages two and three agree
`timescale 1ns/1ps
module pos_sync (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_d,
  output logic      o_q
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s1  <= 1'b0;
      s2  <= 1'b0;
      s3  <= 1'b0;
      o_q <= 1'b0;
    end else begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        o_q <= s3;
      end
    end
  end
endmodule

// ### tb/pos_chk.sv
// concurrent checks on the ports of the command block
`timescale 1ns/1ps
module pos_chk (
  input wire logic                i_mclk,
  input wire logic                i_nrst,
  input wire logic                i_link_clk,
  input wire logic                i_link_nrst,
  input wire logic                i_req_valid,
  input wire pos_pkg::pos_req_t   i_req,
  input wire logic                o_link_busy,
  input wire logic                o_rsp_valid,
  input wire logic [15:0]         o_rsp_data,
  input wire logic                i_control_pin,
  input wire logic                i_fault_event,
  input wire logic                i_fault_present,
  input wire logic [1:0]          i_fault_shutdown,
  input wire logic                i_flash_done,
  input wire logic                i_flash_err,
  input wire pos_pkg::pos_flash_t o_flash,
  input wire logic [1:0]          o_supply_enable_out,
  input wire logic [1:0]          o_fast_off,
  input wire logic                o_monitor_hold,
  input wire logic                o_alert
);
  import pos_pkg::*;
  // --------------------
  // flash handshake
  // --------------------
  sequence flash_wait_s;
    o_flash.start && !i_flash_done;
  endsequence
  sequence flash_end_s;
    o_flash.start && i_flash_done;
  endsequence
  start_held_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    flash_wait_s |=> o_flash.start) else $error("flash start dropped before done");
  start_drop_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    flash_end_s |=> !o_flash.start) else $error("flash start held after done");
  store_sel_stable_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_flash.start && $past(o_flash.start) |-> $stable(o_flash.sel))
    else $error("flash selection moved during transfer");
  store_err_alert_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    flash_end_s ##0 i_flash_err |-> ##[1:8] o_alert) else $error("no alert on store error");
  hold_store_all_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    $rose(o_flash.start) && o_flash.all |-> ##[0:2] o_monitor_hold)
    else $error("monitoring not held during store-all");
  single_no_hold_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_flash.start && !o_flash.all |-> !o_monitor_hold) else $error("single store held monitor");
  // --------------------
  // faults and link
  // --------------------
  fault_alert_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_fault_event |-> ##[1:2] o_alert) else $error("new fault raised no alert");
  shutdown_off_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_fault_shutdown[0] |-> ##[1:3] !o_supply_enable_out[0])
    else $error("latched-off supply still enabled");
  accept_busy_a: assert property (@(posedge i_link_clk) disable iff (!i_link_nrst)
    i_req_valid && !o_link_busy |=> o_link_busy) else $error("request not taken");
  answer_once_a: assert property (@(posedge i_link_clk) disable iff (!i_link_nrst)
    o_rsp_valid |-> !o_link_busy ##1 !o_rsp_valid) else $error("answer not a single pulse");
endmodule

bind pos_core pos_chk u_chk (.i_mclk, .i_nrst, .i_link_clk, .i_link_nrst, .i_req_valid, .i_req,
  .o_link_busy, .o_rsp_valid, .o_rsp_data, .i_control_pin, .i_fault_event, .i_fault_present,
  .i_fault_shutdown, .i_flash_done, .i_flash_err, .o_flash, .o_supply_enable_out, .o_fast_off,
  .o_monitor_hold, .o_alert);

// ### tb/pos_host.sv
// host model: makes the gated link clock and issues one command at a time
`timescale 1ns/1ps
`include "pos_consts.svh"
module pos_host (
  output logic              o_link_clk,
  output logic              o_link_nrst,
  output logic              o_req_valid,
  output pos_pkg::pos_req_t o_req,
  input  wire logic         i_link_busy,
  input  wire logic         i_rsp_valid,
  input  wire logic [15:0]  i_rsp_data
);
  import pos_pkg::*;
  logic run;
  int   n_single;
  // clock stands low between frames
  always begin
    #32;
    if (run || o_link_clk) begin
      o_link_clk = ~o_link_clk;
    end
  end
  initial begin
    o_link_clk = 1'b0;
    o_link_nrst = 1'b0;
    o_req_valid = 1'b0;
    o_req = '0;
    n_single = 0;
    run = 1'b1;
    repeat (4) @(posedge o_link_clk);
    @(negedge o_link_clk);
    o_link_nrst = 1'b1;
    run = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output logic [15:0] rd, output logic ok);
    int n;
    run = 1'b1;
    if (wr && code == `POS_CMD_STORE_ONE) begin
      n_single++;
    end
    @(negedge o_link_clk);
    o_req_valid = 1'b1;
    o_req = '{wr, code, data};
    @(negedge o_link_clk);
    o_req_valid = 1'b0;
    // released lines must not keep the last value
    o_req = ~o_req;
    ok = 1'b0;
    for (n = 0; n < 400 && !ok; n++) begin
      @(negedge o_link_clk);
      ok = i_rsp_valid;
    end
    rd = i_rsp_data;
    run = 1'b0;
  endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the on/off, protection and store command block
`timescale 1ns/1ps
`include "pos_consts.svh"
module tb_top;
  import pos_pkg::*;
  logic        i_mclk, i_nrst, link_clk, link_nrst, req_valid, busy, rsp_valid;
  logic        pin, f_event, f_present, flash_done, flash_err, err_mode, hold, alert;
  logic [1:0]  f_shut, en, fast;
  logic [15:0] rsp_data;
  pos_req_t    req;
  pos_flash_t  flash;
  int          n_mismatch, n_tests, flash_cnt;
  logic [23:0] onoff [11] = '{24'h1e0080, 24'h1e1c80, 24'h1e1040, 24'h1f1c80, 24'h1f0380,
    24'h1c0c80, 24'h1c1080, 24'h181c80, 24'h181300, 24'h140c00, 24'h001c00};
  logic [15:0] dual [4] = '{16'h8112, 16'h8230, 16'h4210, 16'h0101};
  logic [31:0] prot [7] = '{32'h80021f18, 32'h80010080, 32'h40010000, 32'h40021f18,
    32'h20021c1c, 32'h20d10302, 32'h00021818};

  pos_core dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_link_clk(link_clk),
    .i_link_nrst(link_nrst), .i_req_valid(req_valid), .i_req(req), .o_link_busy(busy),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .i_control_pin(pin),
    .i_fault_event(f_event), .i_fault_present(f_present), .i_fault_shutdown(f_shut),
    .i_flash_done(flash_done), .i_flash_err(flash_err), .o_flash(flash),
    .o_supply_enable_out(en), .o_fast_off(fast), .o_monitor_hold(hold), .o_alert(alert));
  pos_host host (.o_link_clk(link_clk), .o_link_nrst(link_nrst), .o_req_valid(req_valid),
    .o_req(req), .i_link_busy(busy), .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data));

  always #4 i_mclk = ~i_mclk;
  // --------------------
  // flash array model
  // --------------------
  always @(negedge i_mclk) begin
    flash_done <= 1'b0;
    flash_err <= err_mode;
    if (flash.start && !flash_done) begin
      flash_cnt <= flash_cnt + 1;
      if (flash_cnt == 5) begin
        flash_done <= 1'b1;
        flash_cnt <= 0;
      end
    end
  end
  // --------------------
  // access tasks
  // --------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] r;
    logic        ok;
    host.xfer(1'b1, c, d, r, ok);
    check("write answer", 16'h1, {15'h0, ok});
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] r;
    logic        ok;
    host.xfer(1'b0, c, 16'h0, r, ok);
    check("read answer", 16'h1, {15'h0, ok});
    check($sformatf("read %h", c), exp, r);
  endtask
  task automatic cml_seen();
    pause(4);
    check("alert", 16'h1, {15'h0, alert});
    rd(`POS_CMD_STATUS, 16'h0002);
    wr(`POS_CMD_CLR_FAULT, 16'h0);
    pause(4);
    check("alert", 16'h0, {15'h0, alert});
    rd(`POS_CMD_STATUS, 16'h0000);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #600000;
    n_mismatch++;
    final_report();
  end
  // --------------------
  // test sequence
  // --------------------
  initial begin
    logic [23:0] e;
    i_mclk = 1'b0;
    i_nrst = 1'b0;
    {pin, f_event, f_present, f_shut, err_mode, flash_done, flash_err} = '0;
    flash_cnt = 0;
    n_mismatch = 0;
    n_tests = 0;
    pause(20);
    i_nrst = 1'b1;
    wait (link_nrst);
    pause(4);
    rd(`POS_CMD_WR_PROT, {8'h0, `POS_WP_RESET});
    rd(`POS_CMD_ONOFF_CFG, {8'h0, `POS_CFG_RESET});
    foreach (onoff[i]) begin
      e = onoff[i];
      wr(`POS_CMD_ONOFF_CFG, {8'h0, e[23:16]});
      @(negedge i_mclk) pin = e[12];
      pause(10);
      wr(`POS_CMD_OPERATION, {8'h0, e[7:0]});
      pause(10);
      check("enable", {14'h0, e[11:10]}, {14'h0, en});
      if (e[11:10] == 2'b00) check("fast off", {14'h0, e[9:8]}, {14'h0, fast});
    end
    wr(`POS_CMD_ONOFF_CFG, 16'h0018);
    wr(`POS_CMD_OPERATION, 16'h0000);
    wr(`POS_CMD_VMODE, 16'h0003);
    foreach (dual[i]) begin
      wr(`POS_CMD_OPERATION, {8'h0, dual[i][15:8]});
      pause(6);
      check("dual enable", {14'h0, dual[i][5:4]}, {14'h0, en});
      check("dual fast", {14'h0, dual[i][1:0]}, {14'h0, fast & ~en});
      rd(`POS_CMD_OPERATION, {8'h0, dual[i][15:8] & `POS_OP_STD_MASK});
    end
    wr(`POS_CMD_PAGE, 16'h0000);
    wr(`POS_CMD_OPERATION, 16'h0081);
    cml_seen();
    check("enable kept", 16'h0, {14'h0, en});
    wr(`POS_CMD_PAGE, {8'h0, `POS_PAGE_ALL});
    wr(`POS_CMD_OPERATION, 16'h0080);
    pause(6);
    check("both on", 16'h3, {14'h0, en});
    wr(`POS_CMD_VMODE, 16'h0002);
    wr(`POS_CMD_OPERATION, 16'h0082);
    cml_seen();
    wr(`POS_CMD_OPERATION, 16'h0055);
    cml_seen();
    @(negedge i_mclk) f_present = 1'b1;
    f_event = 1'b1;
    @(negedge i_mclk) f_event = 1'b0;
    rd(`POS_CMD_STATUS, 16'h0001);
    wr(`POS_CMD_CLR_FAULT, 16'h0);
    pause(6);
    check("alert after clear", 16'h0, {15'h0, alert});
    rd(`POS_CMD_STATUS, 16'h0001);
    @(negedge i_mclk) f_shut = 2'b01;
    @(negedge i_mclk) f_shut = 2'b00;
    wr(`POS_CMD_CLR_FAULT, 16'h0);
    pause(6);
    check("latched off", 16'h2, {14'h0, en});
    @(negedge i_mclk) f_present = 1'b0;
    f_event = 1'b1;
    @(negedge i_mclk) f_event = 1'b0;
    pause(2);
    check("new fault alert", 16'h1, {15'h0, alert});
    wr(`POS_CMD_CLR_FAULT, 16'h0);
    foreach (prot[i]) begin
      wr(`POS_CMD_WR_PROT, {8'h0, prot[i][31:24]});
      rd(`POS_CMD_WR_PROT, {8'h0, prot[i][31:24]});
      wr(prot[i][23:16], {8'h0, prot[i][15:8]});
      rd(prot[i][23:16], {8'h0, prot[i][7:0]});
    end
    rd(`POS_CMD_STATUS, 16'h0000);
    check("no alert", 16'h0, {15'h0, alert});
    wr(`POS_CMD_STORE_ONE, 16'h0460);
    rd(`POS_CMD_STORE_ONE, 16'h0460);
    wr(`POS_CMD_STORE_ALL, 16'h0);
    rd(`POS_CMD_STATUS, 16'h0000);
    err_mode = 1'b1;
    wr(`POS_CMD_STORE_ALL, 16'h0);
    cml_seen();
    wr(`POS_CMD_STORE_ONE, 16'h0561);
    cml_seen();
    rd(`POS_CMD_STORE_ONE, 16'h0460);
    final_report();
  end
endmodule
